//--- pkg/dcu_map.svh
// Offsets, field positions and reset values of the synthesizer control word
`ifndef DCU_MAP_SVH
`define DCU_MAP_SVH

`define DCU_ADDR_W 6
`define DCU_ADDR_B3 6'h1D
`define DCU_ADDR_B2 6'h1E
`define DCU_ADDR_B1 6'h1F
`define DCU_ADDR_B0 6'h20

`define DCU_BIT_CMP_PD 28
`define DCU_BIT_HALT 27
`define DCU_BIT_CDAC_PD 26
`define DCU_BIT_DAC_PD 25
`define DCU_BIT_DIG_PD 24
`define DCU_BIT_RSVD 23
`define DCU_BIT_RANGE 22
`define DCU_BIT_BYPASS 21
`define DCU_MULT_MSB 20
`define DCU_MULT_LSB 16
`define DCU_BIT_CLR1 15
`define DCU_BIT_CLRALL 14
`define DCU_BIT_TRI 13

// Bits 28,26:24,22:16,14,13 are stored; open, halt, reserved, one-shot and don't-care are not
`define DCU_STORE_MASK 32'h177F6000
`define DCU_RESET_VAL 32'h00600000

`define DCU_MULT_MIN 5'h04
`define DCU_MULT_MAX 5'h14
`define DCU_MODE_RAMP_FSK 3'h2

`endif

//--- pkg/dcu_pkg.sv
// Types shared by the synthesizer control word logic
`default_nettype none
package dcu_pkg;
    typedef enum logic [0:0] {
        DCU_SWEEP_UP = 1'b0,
        DCU_SWEEP_DOWN = 1'b1
    } dcu_sweep_t;
endpackage
`default_nettype wire

//--- rtl/dcu_ctrl_top.sv
// Upper control word fields of the synthesizer with their power-down and clear outputs
//
// What this block does
// (RULE1) Comparator power-down field drives a power-down indication to the comparator.
// (RULE2) A one written to the halt field stops the device until master reset.
// (RULE3) Control converter power-down field powers down the control converter only.
// (RULE4) Full converter power-down field powers down both converters and the reference.
// (RULE5) Digital power-down stops digital clocks; multiplier loop keeps running.
// (RULE6) Host writes zero to the reserved field below digital power-down.
// (RULE7) Loop range selects oscillator gain, resets to one; keep one above 200 MHz.
// (RULE8) Bypass field powers down the loop and clocks from reference; resets to one.
// (RULE9) Five-bit multiplication factor sets the ratio unless bypassed; legal range 4 to 20.
// (RULE10) One-shot clear field sends one clear pulse to accumulator one, then self-clears.
// (RULE11) The one-shot clear works in every operating mode.
// (RULE12) Level clear field holds both accumulators at zero while set.
// (RULE13) Triangle field sweeps first to second tuning frequency and back, forever.
// (RULE14) Host sets ramped frequency-shift mode whenever triangle is set.
// (RULE15) Operating mode code 0x2 is the ramped frequency-shift mode.
// (RULE16) The control word sits at byte addresses 1D hex through 20 hex.
// (RULE17) Open bits 31 to 29 and bit 12 are ignored on write, read zero.
`timescale 1ns/1ps
`default_nettype none
`include "dcu_map.svh"

module dcu_ctrl_top #(
    parameter int MULT_W = 5
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [`DCU_ADDR_W-1:0] prog_addr,
    input wire logic [7:0] prog_wdata,
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic [2:0] op_mode,
    input wire logic at_first_tuning_frequency,
    input wire logic at_second_tuning_frequency,
    output logic [7:0] prog_rdata,
    output logic comparator_pd,
    output logic control_dac_pd,
    output logic cosine_dac_pd,
    output logic dac_reference_pd,
    output logic digital_clock_stop,
    output logic pll_power_down,
    output logic pll_high_gain,
    output logic system_clock_from_reference,
    output logic [MULT_W-1:0] pll_mult_factor,
    output logic pll_mult_out_of_range,
    output logic acc1_clear_pulse,
    output logic acc_hold_clear,
    output logic sweep_active,
    output logic sweep_down,
    output logic device_halted
);

    // Field width is fixed by the word layout
    if (MULT_W != `DCU_MULT_MSB - `DCU_MULT_LSB + 1) begin
        $error("MULT_W must match the multiplier field width");
    end
    if (`DCU_MULT_MAX >= (1 << MULT_W)) begin
        $error("MULT_W too narrow for the largest legal factor");
    end

    logic [31:0] word_reg;
    logic [31:0] word_next;
    logic halt_reg;
    logic halt_next;
    logic clr1_reg;
    logic clr1_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    dcu_pkg::dcu_sweep_t sweep_reg;
    dcu_pkg::dcu_sweep_t sweep_next;
    logic cmp_pd_reg;
    logic cmp_pd_next;
    logic cdac_pd_reg;
    logic cdac_pd_next;
    logic cos_pd_reg;
    logic cos_pd_next;
    logic ref_pd_reg;
    logic ref_pd_next;
    logic clk_stop_reg;
    logic clk_stop_next;
    logic pll_pd_reg;
    logic pll_pd_next;
    logic gain_reg;
    logic gain_next;
    logic reference_clock_input_sel_reg;
    logic reference_clock_input_sel_next;
    logic mult_bad_reg;
    logic mult_bad_next;
    logic pulse_reg;
    logic pulse_next;
    logic hold_reg;
    logic hold_next;
    logic sweep_on_reg;
    logic sweep_on_next;
    logic dir_reg;
    logic dir_next;
    logic halted_reg;
    logic halted_next;
    logic [MULT_W-1:0] mult_reg;
    logic [MULT_W-1:0] mult_next;
    logic wr_ok;
    logic tri_run;
    logic mult_low;
    logic mult_high;

    // Halted part answers nothing until master reset
    assign wr_ok = prog_wr && !halt_reg;

    // (RULE15) ramp mode code
    assign tri_run = word_reg[`DCU_BIT_TRI] && (op_mode == `DCU_MODE_RAMP_FSK);

    // (RULE9) legal factor window
    assign mult_low = word_reg[`DCU_MULT_MSB:`DCU_MULT_LSB] < `DCU_MULT_MIN;
    assign mult_high = word_reg[`DCU_MULT_MSB:`DCU_MULT_LSB] > `DCU_MULT_MAX;

    always_comb begin
        word_next = word_reg;
        halt_next = halt_reg;
        clr1_next = 1'b0;
        if (wr_ok) begin
            unique case (prog_addr)
                // (RULE16) byte lanes of the word
                `DCU_ADDR_B3: begin
                    // (RULE17) open bits dropped by mask
                    word_next[31:24] = prog_wdata & 8'(`DCU_STORE_MASK >> 24);
                    // No write clears it, only master reset
                    // (RULE2) latching halt
                    if (prog_wdata[`DCU_BIT_HALT-24]) begin
                        halt_next = 1'b1;
                    end
                end
                `DCU_ADDR_B2: begin
                    // (RULE6) reserved bit not stored
                    word_next[23:16] = prog_wdata & 8'(`DCU_STORE_MASK >> 16);
                end
                `DCU_ADDR_B1: begin
                    word_next[15:8] = prog_wdata & 8'(`DCU_STORE_MASK >> 8);
                    // (RULE10) one-shot, never stored
                    // (RULE11) no mode qualifier
                    clr1_next = prog_wdata[`DCU_BIT_CLR1-8];
                end
                default: begin
                    word_next = word_reg;
                end
            endcase
        end
    end

    // Read byte held until the next taken read
    always_comb begin
        rdata_next = rdata_reg;
        if (prog_rd && !halt_reg) begin
            unique case (prog_addr)
                `DCU_ADDR_B3: rdata_next = word_reg[31:24];
                `DCU_ADDR_B2: rdata_next = word_reg[23:16];
                `DCU_ADDR_B1: rdata_next = word_reg[15:8];
                // Lower fields live elsewhere; unmapped reads give zero
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // (RULE13) triangle turnaround at each end
    always_comb begin
        sweep_next = sweep_reg;
        // Resting at up, so every new sweep starts upward
        if (!tri_run) begin
            sweep_next = dcu_pkg::DCU_SWEEP_UP;
        end else begin
            unique case (sweep_reg)
                dcu_pkg::DCU_SWEEP_UP: begin
                    if (at_second_tuning_frequency) begin
                        sweep_next = dcu_pkg::DCU_SWEEP_DOWN;
                    end
                end
                dcu_pkg::DCU_SWEEP_DOWN: begin
                    if (at_first_tuning_frequency) begin
                        sweep_next = dcu_pkg::DCU_SWEEP_UP;
                    end
                end
            endcase
        end
    end

    // Outputs registered so downstream sees clean levels
    always_comb begin
        // (RULE1) comparator
        cmp_pd_next = word_reg[`DCU_BIT_CMP_PD];
        // (RULE3) control converter, (RULE4) full converter
        cdac_pd_next = word_reg[`DCU_BIT_CDAC_PD] | word_reg[`DCU_BIT_DAC_PD];
        // (RULE4) cosine converter and reference
        cos_pd_next = word_reg[`DCU_BIT_DAC_PD];
        ref_pd_next = word_reg[`DCU_BIT_DAC_PD];
        // (RULE5) digital clocks stop, loop untouched
        clk_stop_next = word_reg[`DCU_BIT_DIG_PD] | halt_reg;
        // (RULE8) bypass powers loop down
        pll_pd_next = word_reg[`DCU_BIT_BYPASS];
        // (RULE7) oscillator gain
        gain_next = word_reg[`DCU_BIT_RANGE];
        reference_clock_input_sel_next = word_reg[`DCU_BIT_BYPASS];
        // (RULE9) flagged, not clamped, so a host fault stays visible
        mult_bad_next = !word_reg[`DCU_BIT_BYPASS] && (mult_low || mult_high);
        // (RULE10) single pulse to accumulator one
        pulse_next = clr1_reg;
        // (RULE12) hold both accumulators
        hold_next = word_reg[`DCU_BIT_CLRALL];
        // (RULE13) sweep state
        sweep_on_next = tri_run;
        dir_next = (sweep_reg == dcu_pkg::DCU_SWEEP_DOWN);
        // (RULE2) halt indication
        halted_next = halt_reg;
        // (RULE9) factor passed on unchanged, bypassed or not
        mult_next = word_reg[`DCU_MULT_MSB:`DCU_MULT_LSB];
    end

    // (RULE7) (RULE8) range and bypass reset high
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            word_reg <= `DCU_RESET_VAL;
            halt_reg <= 1'b0;
            clr1_reg <= 1'b0;
        end else if (ce) begin
            word_reg <= word_next;
            halt_reg <= halt_next;
            clr1_reg <= clr1_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 8'h00;
        end else if (ce) begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sweep_reg <= dcu_pkg::DCU_SWEEP_UP;
        end else if (ce) begin
            sweep_reg <= sweep_next;
        end
    end

    // Output flops freeze with ce like all other state
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmp_pd_reg <= 1'b0;
            cdac_pd_reg <= 1'b0;
            cos_pd_reg <= 1'b0;
            ref_pd_reg <= 1'b0;
            clk_stop_reg <= 1'b0;
            pll_pd_reg <= 1'b1;
            gain_reg <= 1'b1;
            reference_clock_input_sel_reg <= 1'b1;
            mult_bad_reg <= 1'b0;
            pulse_reg <= 1'b0;
            hold_reg <= 1'b0;
            sweep_on_reg <= 1'b0;
            dir_reg <= 1'b0;
            halted_reg <= 1'b0;
            mult_reg <= '0;
        end else if (ce) begin
            cmp_pd_reg <= cmp_pd_next;
            cdac_pd_reg <= cdac_pd_next;
            cos_pd_reg <= cos_pd_next;
            ref_pd_reg <= ref_pd_next;
            clk_stop_reg <= clk_stop_next;
            pll_pd_reg <= pll_pd_next;
            gain_reg <= gain_next;
            reference_clock_input_sel_reg <= reference_clock_input_sel_next;
            mult_bad_reg <= mult_bad_next;
            pulse_reg <= pulse_next;
            hold_reg <= hold_next;
            sweep_on_reg <= sweep_on_next;
            dir_reg <= dir_next;
            halted_reg <= halted_next;
            mult_reg <= mult_next;
        end
    end

    assign prog_rdata = rdata_reg;
    assign comparator_pd = cmp_pd_reg;
    assign control_dac_pd = cdac_pd_reg;
    assign cosine_dac_pd = cos_pd_reg;
    assign dac_reference_pd = ref_pd_reg;
    assign digital_clock_stop = clk_stop_reg;
    assign pll_power_down = pll_pd_reg;
    assign pll_high_gain = gain_reg;
    assign system_clock_from_reference = reference_clock_input_sel_reg;
    assign pll_mult_out_of_range = mult_bad_reg;
    assign acc1_clear_pulse = pulse_reg;
    assign acc_hold_clear = hold_reg;
    assign sweep_active = sweep_on_reg;
    assign sweep_down = dir_reg;
    assign device_halted = halted_reg;
    assign pll_mult_factor = mult_reg;

endmodule

`default_nettype wire

//--- sim/dcu_ctrl_top_asserts.sv
// Checker for the synthesizer control word outputs
`timescale 1ns/1ps
`default_nettype none
`include "dcu_map.svh"
module dcu_ctrl_top_asserts #(
    parameter int MULT_W = 5
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [`DCU_ADDR_W-1:0] prog_addr,
    input wire logic [7:0] prog_wdata,
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic [2:0] op_mode,
    input wire logic [7:0] prog_rdata,
    input wire logic comparator_pd,
    input wire logic control_dac_pd,
    input wire logic cosine_dac_pd,
    input wire logic dac_reference_pd,
    input wire logic digital_clock_stop,
    input wire logic pll_power_down,
    input wire logic system_clock_from_reference,
    input wire logic [MULT_W-1:0] pll_mult_factor,
    input wire logic pll_mult_out_of_range,
    input wire logic acc1_clear_pulse,
    input wire logic sweep_active,
    input wire logic device_halted
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Refused while halted, so only live writes count
    wire logic wr_ok = ce && prog_wr && !device_halted;
    ref_pair_a: assert property (cosine_dac_pd == dac_reference_pd)
        else $error("reference and cosine power-down differ");
    ctl_dac_a: assert property (cosine_dac_pd |-> control_dac_pd)
        else $error("control converter up during full power-down");
    bypass_pair_a: assert property (pll_power_down == system_clock_from_reference)
        else $error("bypass outputs differ");
    range_flag_a: assert property (pll_mult_out_of_range == (!pll_power_down &&
        (pll_mult_factor < 5'h04 || pll_mult_factor > 5'h14))) else $error("range flag wrong");
    clr_pulse_a: assert property (wr_ok && prog_addr == `DCU_ADDR_B1 && prog_wdata[7]
        |-> ##2 acc1_clear_pulse ##1 !acc1_clear_pulse) else $error("clear pulse wrong");
    cmp_pd_a: assert property (wr_ok && prog_addr == `DCU_ADDR_B3
        |-> ##2 comparator_pd == $past(prog_wdata[4], 2)) else $error("comparator pd wrong");
    halt_hold_a: assert property (device_halted |=> device_halted && digital_clock_stop)
        else $error("halt not held");
    sweep_mode_a: assert property (sweep_active |-> $past(op_mode) == 3'h2)
        else $error("sweep outside ramped mode");
    unmapped_rd_a: assert property (ce && prog_rd && !device_halted &&
        (prog_addr < `DCU_ADDR_B3 || prog_addr > `DCU_ADDR_B1) |=> prog_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind dcu_ctrl_top dcu_ctrl_top_asserts #(.MULT_W(MULT_W)) u_chk (.clk_sys, .rst_b, .ce,
    .prog_addr, .prog_wdata, .prog_wr, .prog_rd, .op_mode, .prog_rdata, .comparator_pd,
    .control_dac_pd, .cosine_dac_pd, .dac_reference_pd, .digital_clock_stop, .pll_power_down,
    .system_clock_from_reference, .pll_mult_factor, .pll_mult_out_of_range,
    .acc1_clear_pulse, .sweep_active, .device_halted);
`default_nettype wire

//--- sim/dcu_ctrl_top_bench.sv
// Self-checking bench for the upper control word fields
`timescale 1ns/1ps
`default_nettype none
`include "dcu_map.svh"
module dcu_ctrl_top_bench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic [2:0] op_mode = 3'h0;
    logic at_first_tuning_frequency = 1'b0;
    logic at_second_tuning_frequency = 1'b0;
    wire logic [`DCU_ADDR_W-1:0] prog_addr;
    wire logic [7:0] prog_wdata, prog_rdata;
    wire logic [4:0] pll_mult_factor;
    wire logic prog_wr, prog_rd, comparator_pd, control_dac_pd, cosine_dac_pd;
    wire logic dac_reference_pd, digital_clock_stop, pll_power_down, pll_high_gain;
    wire logic system_clock_from_reference, pll_mult_out_of_range, acc1_clear_pulse;
    wire logic acc_hold_clear, sweep_active, sweep_down, device_halted;
    int bad_count = 0;
    int n_compared = 0;
    int seed = 32'h2f34;
    logic [7:0] exp_q[$];
    logic [7:0] fac[4] = '{8'h43, 8'h44, 8'h54, 8'h55};
    logic [7:0] v, e;
    dcu_ctrl_top u_dut (.clk_sys, .rst_b, .ce, .prog_addr, .prog_wdata, .prog_wr, .prog_rd,
        .op_mode, .at_first_tuning_frequency, .at_second_tuning_frequency, .prog_rdata,
        .comparator_pd, .control_dac_pd, .cosine_dac_pd, .dac_reference_pd,
        .digital_clock_stop, .pll_power_down, .pll_high_gain, .system_clock_from_reference,
        .pll_mult_factor, .pll_mult_out_of_range, .acc1_clear_pulse, .acc_hold_clear,
        .sweep_active, .sweep_down, .device_halted);
    dcu_host_model u_host (.clk_sys, .prog_addr, .prog_wdata, .prog_wr, .prog_rd);
    initial forever #5 clk_sys = ~clk_sys;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        u_host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic results;
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Halted reads leave rdata frozen, so no note is taken off
    always @(posedge clk_sys) begin
        if (rst_b && ce && prog_rd && !device_halted && exp_q.size() > 0) begin
            #2;
            chk(prog_rdata, exp_q.pop_front());
        end
    end
    initial begin
        #200000;
        bad_count++;
        results;
    end
    initial begin
        wt(16);
        rst_b = 1'b1;
        chk(8'({pll_high_gain, pll_power_down}), 8'h03);
        rd(6'h1D, 8'h00);
        rd(6'h1E, 8'h60);
        rd(6'h20, 8'h00);
        rd(6'h05, 8'h00);
        u_host.xfer(1'b1, 6'h1D, 8'hF7);
        rd(6'h1D, 8'h17);
        chk(8'({comparator_pd, control_dac_pd, cosine_dac_pd, dac_reference_pd,
            digital_clock_stop}), 8'h1F);
        u_host.xfer(1'b1, 6'h1D, 8'h04);
        wt(1);
        chk(8'({comparator_pd, control_dac_pd, cosine_dac_pd}), 8'h02);
        // Write refused while ce is low
        ce = 1'b0;
        u_host.xfer(1'b1, 6'h1D, 8'h10);
        ce = 1'b1;
        rd(6'h1D, 8'h04);
        chk(8'(comparator_pd), 8'h00);
        for (int i = 0; i < 7; i++) begin
            v = (i < 4) ? fac[i] : 8'($random(seed));
            u_host.xfer(1'b1, 6'h1E, v);
            e = v & 8'h7F;
            rd(6'h1E, e);
            chk(8'({pll_high_gain, system_clock_from_reference, pll_mult_factor}), e);
            chk(8'(pll_mult_out_of_range), 8'(!e[5] && (e[4:0] < 5'h04 || e[4:0] > 5'h14)));
        end
        for (int m = 0; m < 5; m++) begin
            op_mode = 3'(m);
            u_host.xfer(1'b1, 6'h1F, 8'hFF);
            wt(1);
            chk(8'(acc1_clear_pulse), 8'h01);
            wt(1);
            chk(8'(acc1_clear_pulse), 8'h00);
            rd(6'h1F, 8'h60);
            chk(8'({acc_hold_clear, sweep_active}), 8'({1'b1, m == 2}));
        end
        op_mode = 3'h2;
        at_second_tuning_frequency = 1'b1;
        wt(3);
        chk(8'({sweep_active, sweep_down}), 8'h03);
        at_second_tuning_frequency = 1'b0;
        at_first_tuning_frequency = 1'b1;
        wt(3);
        chk(8'(sweep_down), 8'h00);
        u_host.xfer(1'b1, 6'h1F, 8'h00);
        rd(6'h1F, 8'h00);
        chk(8'(acc_hold_clear), 8'h00);
        u_host.xfer(1'b1, 6'h1D, 8'h08);
        wt(2);
        chk(8'({device_halted, digital_clock_stop}), 8'h03);
        u_host.xfer(1'b1, 6'h1E, 8'h00);
        wt(2);
        chk(8'(pll_mult_factor), 8'(e[4:0]));
        rst_b = 1'b0;
        wt(16);
        rst_b = 1'b1;
        chk(8'(device_halted), 8'h00);
        rd(6'h1E, 8'h60);
        for (int i = 0; i < 8 && exp_q.size() > 0; i++)
            wt(1);
        if (exp_q.size() > 0)
            bad_count++;
        results;
    end
endmodule
`default_nettype wire

//--- sim/dcu_host_model.sv
// Host side model driving the byte programming port
`timescale 1ns/1ps
`default_nettype none
`include "dcu_map.svh"
module dcu_host_model (
    input wire logic clk_sys,
    output logic [`DCU_ADDR_W-1:0] prog_addr,
    output logic [7:0] prog_wdata,
    output logic prog_wr,
    output logic prog_rd
);
    initial begin
        prog_addr = 6'h00;
        prog_wdata = 8'h00;
        prog_wr = 1'b0;
        prog_rd = 1'b0;
    end
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        prog_addr = a;
        prog_wdata = (a == `DCU_ADDR_B2) ? (d & 8'h7F) : d;
        prog_wr = w;
        prog_rd = !w;
        @(posedge clk_sys);
        #1;
        prog_wr = 1'b0;
        prog_rd = 1'b0;
        // Released data no longer shows the old byte
        prog_wdata = ~prog_wdata;
    endtask
endmodule
`default_nettype wire
